//--- logic/dmc_cfg_mem.sv
// Purpose: per-channel mode and extended mode storage
// Assumes: one write per cycle, writes come from the host decode
// Notes:   outputs are the storage flops themselves
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"

module dmc_cfg_mem #(
	parameter int NCH = `DMC_NUM_CHAN
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	input  wire logic               mclr,
	input  wire logic               we_mode,
	input  wire logic               we_ext,
	input  wire logic [2:0]         waddr,
	input  wire logic [5:0]         wdata,
	output dmc_pkg::dmc_mode_t [7:0] mode,
	output dmc_pkg::dmc_ext_t [7:0]  ext
);
	import dmc_pkg::*;

	if (NCH != `DMC_NUM_CHAN) begin : g_chk
		$error("dmc_cfg_mem serves exactly eight channels");
	end

	dmc_mem_t s_q;
	dmc_mem_t s_d;

	// the cascade channel never leaves cascade
	function automatic dmc_mode_t mode_rst(input int c);
		dmc_mode_t m;
		m = '0;
		if (c == int'(`DMC_CASCADE_CHAN)) begin
			m.xfer_mode = `DMC_XMODE_CASCADE;
		end
		return m;
	endfunction

	always_comb begin
		s_d = s_q;
		if (we_mode) begin
			s_d.mode[waddr] = dmc_mode_t'(wdata);
			if (waddr == `DMC_CASCADE_CHAN) begin
				s_d.mode[waddr].xfer_mode = `DMC_XMODE_CASCADE;
			end
		end
		if (we_ext) begin
			s_d.ext[waddr] = dmc_ext_t'(wdata);
		end
		// master clear resets modes but keeps extended modes
		if (mclr) begin
			for (int c = 0; c < NCH; c++) begin
				s_d.mode[c] = mode_rst(c);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			for (int c = 0; c < NCH; c++) begin
				s_q.mode[c] <= mode_rst(c);
				s_q.ext[c] <= '0;
				s_q.ext[c].data_size <= (c < `DMC_GRP_CHAN) ? `DMC_SIZE_RST_LO
					: `DMC_SIZE_RST_HI;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign mode = s_q.mode;
	assign ext = s_q.ext;
endmodule
`default_nettype wire

//--- logic/dmc_mode_ctrl.sv
// Purpose: command, mode and extended mode control for two DMA channel groups
// Assumes: host writes arrive as one-cycle strobes on clk_sys; request pins are async
// Notes:   request, address, count and page registers live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"

module dmc_mode_ctrl #(
	parameter int NCH = `DMC_NUM_CHAN
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	input  wire dmc_pkg::dmc_io_wr_t     io_wr,
	input  wire logic                    master_clear,
	input  wire logic [7:0]              channel_request_line,
	input  wire logic [7:0]              terminal_count,
	input  wire logic [7:0]              isa_mem_target,
	output logic [7:0]                   channel_acknowledge_line,
	output dmc_pkg::dmc_chan_cfg_t [7:0] chan_cfg,
	output logic [7:0]                   reload_base,
	output logic [1:0]                   group_enabled
);
	import dmc_pkg::*;

	if (NCH != `DMC_NUM_CHAN) begin : g_chk
		$error("dmc_mode_ctrl serves exactly eight channels");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// returns {valid, index}; the first active request at or after base wins
	function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] base);
		logic [2:0] r;
		logic [1:0] k;
		r = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			k = base + 2'(i);
			if (req[k]) begin
				r = {1'b1, k};
			end
		end
		return r;
	endfunction

	function automatic dmc_cmd_t cmd_decode(input logic [7:0] d);
		dmc_cmd_t c;
		c.ack_high = d[`DMC_CMD_ACK_POL];
		c.req_low = d[`DMC_CMD_REQ_SENSE];
		c.rotate = d[`DMC_CMD_ROTATE];
		c.disable_grp = d[`DMC_CMD_DISABLE];
		return c;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dmc_state_t      s_q;
	dmc_state_t      s_d;
	dmc_mode_t [7:0] mode_q;
	dmc_ext_t [7:0]  ext_q;
	logic            mem_we_mode;
	logic            mem_we_ext;
	logic [2:0]      mem_waddr;
	logic [5:0]      mem_wdata;

	// ----------------------------------------------------------------
	// host write decode
	// ----------------------------------------------------------------
	logic hit_mode_lo;
	logic hit_mode_hi;
	logic hit_ext_lo;
	logic hit_ext_hi;

	always_comb begin
		hit_mode_lo = io_wr.wr && (io_wr.addr == `DMC_OFS_MODE_LO);
		hit_mode_hi = io_wr.wr && (io_wr.addr == `DMC_OFS_MODE_HI);
		hit_ext_lo = io_wr.wr && (io_wr.addr == `DMC_OFS_EXT_LO);
		hit_ext_hi = io_wr.wr && (io_wr.addr == `DMC_OFS_EXT_HI);
		// master clear wins over a mode write landing in the same cycle
		mem_we_mode = (hit_mode_lo || hit_mode_hi) && !master_clear;
		mem_we_ext = hit_ext_lo || hit_ext_hi;
		mem_waddr = {hit_mode_hi || hit_ext_hi,
			io_wr.data[`DMC_SEL_HI:`DMC_SEL_LO]};
		mem_wdata = io_wr.data[`DMC_FIELD_HI:`DMC_FIELD_LO];
	end

	dmc_cfg_mem #(
		.NCH (NCH)
	) u_mem (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.mclr    (master_clear),
		.we_mode (mem_we_mode),
		.we_ext  (mem_we_ext),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.mode    (mode_q),
		.ext     (ext_q)
	);

	// ----------------------------------------------------------------
	// group enables, request decode and arbitration
	// ----------------------------------------------------------------
	logic       en_hi;
	logic       en_lo;
	logic [7:0] req_act;
	logic [3:0] req_grp [2];
	logic       low_pending;
	logic [1:0] gate;
	logic [2:0] win;

	always_comb begin
		s_d = s_q;
		// request pins pass two flops before anything looks at them
		s_d.req_s1 = channel_request_line;
		s_d.req_s2 = s_q.req_s1;

		if (master_clear) begin
			s_d.cmd = '0;
		end else begin
			if (io_wr.wr && (io_wr.addr == `DMC_OFS_CMD_LO)) begin
				s_d.cmd[0] = cmd_decode(io_wr.data);
			end
			if (io_wr.wr && (io_wr.addr == `DMC_OFS_CMD_HI)) begin
				s_d.cmd[1] = cmd_decode(io_wr.data);
			end
		end

		en_hi = !s_q.cmd[1].disable_grp;
		en_lo = en_hi && !s_q.cmd[0].disable_grp;

		// one sense bit per group, never per channel
		for (int c = 0; c < NCH; c++) begin
			req_act[c] = s_q.req_s2[c] ^ s_q.cmd[c / `DMC_GRP_CHAN].req_low;
		end
		low_pending = en_lo && (|req_act[3:0]);
		req_grp[0] = req_act[3:0];
		// the upper group's first channel carries the lower group's demand
		req_grp[1] = {req_act[7:5], low_pending};
		gate[1] = en_hi;
		gate[0] = en_lo && (s_q.arb[1].st == ARB_BUSY) && (s_q.arb[1].idx == 2'h0);

		for (int g = 0; g < 2; g++) begin
			win = pick(req_grp[g], s_q.cmd[g].rotate ? s_q.arb[g].base : 2'h0);
			unique case (s_q.arb[g].st)
				ARB_IDLE: begin
					if (gate[g] && win[2]) begin
						s_d.arb[g].st = ARB_BUSY;
						s_d.arb[g].idx = win[1:0];
					end
				end
				ARB_BUSY: begin
					if (!gate[g] || !req_grp[g][s_q.arb[g].idx]) begin
						s_d.arb[g].st = ARB_IDLE;
						// the channel just served drops to the bottom
						s_d.arb[g].base = s_q.arb[g].idx + 2'h1;
					end
				end
			endcase
		end
		if (master_clear) begin
			s_d.arb = '0;
		end

		// registered per-channel view for the sequencer
		for (int c = 0; c < NCH; c++) begin
			s_d.cfg[c].xfer_mode = mode_q[c].xfer_mode;
			s_d.cfg[c].addr_decr = mode_q[c].addr_decr;
			s_d.cfg[c].autoinit = mode_q[c].autoinit;
			s_d.cfg[c].xfer_type = (mode_q[c].xfer_mode == `DMC_XMODE_CASCADE)
				? `DMC_XTYPE_VERIFY : mode_q[c].xfer_type;
			s_d.cfg[c].strobe_en = (mode_q[c].xfer_mode != `DMC_XMODE_CASCADE)
				&& (mode_q[c].xfer_type != `DMC_XTYPE_VERIFY)
				&& (mode_q[c].xfer_type != `DMC_XTYPE_ILLEGAL);
			// extended timings reach main memory only
			s_d.cfg[c].timing = isa_mem_target[c] ? `DMC_TIMING_COMPAT
				: ext_q[c].timing;
			s_d.cfg[c].data_size = ext_q[c].data_size;
			s_d.cfg[c].eop_in = ext_q[c].eop_in;
			s_d.reload[c] = terminal_count[c] && mode_q[c].autoinit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// the cascade channel has no pin; it idles at the inactive level
	for (genvar c = 0; c < NCH; c++) begin : g_ack
		localparam int G = c / `DMC_GRP_CHAN;
		localparam logic [1:0] L = 2'(c % `DMC_GRP_CHAN);
		logic asserted;
		assign asserted = (c != int'(`DMC_CASCADE_CHAN)) && (s_q.arb[G].st == ARB_BUSY)
			&& (s_q.arb[G].idx == L);
		assign channel_acknowledge_line[c] = asserted ? s_q.cmd[G].ack_high
			: !s_q.cmd[G].ack_high;
	end

	assign chan_cfg = s_q.cfg;
	assign reload_base = s_q.reload;
	assign group_enabled = {!s_q.cmd[1].disable_grp,
		!s_q.cmd[1].disable_grp && !s_q.cmd[0].disable_grp};
endmodule
`default_nettype wire

//--- logic/dmc_params.svh
// Purpose: constants for the DMA channel mode control block
// Assumes: 16-bit host I/O addresses, 8-bit write data
// Notes:   definitions only
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// ----------------------------------------------------------------
// host I/O offsets
// ----------------------------------------------------------------
`define DMC_OFS_CMD_LO     16'h0008
`define DMC_OFS_CMD_HI     16'h00D0
`define DMC_OFS_MODE_LO    16'h000B
`define DMC_OFS_MODE_HI    16'h00D6
`define DMC_OFS_EXT_LO     16'h040B
`define DMC_OFS_EXT_HI     16'h04D6

// ----------------------------------------------------------------
// command register bit positions
// ----------------------------------------------------------------
`define DMC_CMD_ACK_POL    7
`define DMC_CMD_REQ_SENSE  6
`define DMC_CMD_ROTATE     4
`define DMC_CMD_DISABLE    2

// ----------------------------------------------------------------
// mode write layout: select bits and stored field
// ----------------------------------------------------------------
`define DMC_SEL_HI         1
`define DMC_SEL_LO         0
`define DMC_FIELD_HI       7
`define DMC_FIELD_LO       2

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define DMC_XMODE_DEMAND   2'h0
`define DMC_XMODE_CASCADE  2'h3
`define DMC_XTYPE_VERIFY   2'h0
`define DMC_XTYPE_ILLEGAL  2'h3
`define DMC_TIMING_COMPAT  2'h0
`define DMC_SIZE_RST_LO    2'h0
`define DMC_SIZE_RST_HI    2'h1
`define DMC_CASCADE_CHAN   3'h4
`define DMC_NUM_CHAN       8
`define DMC_GRP_CHAN       4

`endif

//--- logic/dmc_pkg.sv
// Purpose: types shared by the DMA channel mode control block
// Assumes: dmc_params.svh supplies the numeric constants
// Notes:   all state structs live here
package dmc_pkg;

	// host I/O write strobe with its address and data
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic        wr;
	} dmc_io_wr_t;

	// stored upper six bits of a channel mode write
	typedef struct packed {
		logic [1:0] xfer_mode;
		logic       addr_decr;
		logic       autoinit;
		logic [1:0] xfer_type;
	} dmc_mode_t;

	// stored upper six bits of an extended mode write
	typedef struct packed {
		logic       rsvd;
		logic       eop_in;
		logic [1:0] timing;
		logic [1:0] data_size;
	} dmc_ext_t;

	typedef struct packed {
		logic ack_high;
		logic req_low;
		logic rotate;
		logic disable_grp;
	} dmc_cmd_t;

	typedef enum logic {ARB_IDLE, ARB_BUSY} dmc_arb_st_t;

	typedef struct packed {
		dmc_arb_st_t st;
		logic [1:0]  idx;
		logic [1:0]  base;
	} dmc_arb_t;

	// effective per-channel settings seen by the transfer sequencer
	typedef struct packed {
		logic [1:0] xfer_mode;
		logic       addr_decr;
		logic       autoinit;
		logic [1:0] xfer_type;
		logic       strobe_en;
		logic [1:0] timing;
		logic [1:0] data_size;
		logic       eop_in;
	} dmc_chan_cfg_t;

	typedef struct packed {
		dmc_cmd_t [1:0]      cmd;
		logic [7:0]          req_s1;
		logic [7:0]          req_s2;
		dmc_arb_t [1:0]      arb;
		dmc_chan_cfg_t [7:0] cfg;
		logic [7:0]          reload;
	} dmc_state_t;

	typedef struct packed {
		dmc_mode_t [7:0] mode;
		dmc_ext_t [7:0]  ext;
	} dmc_mem_t;

endpackage

//--- tb/dmc_isa_slave.sv
// Purpose: far-side slave that drives the request pins
// Assumes: bench sets want and the sense level of each group
// Notes:   a released pin sits at its inactive level
`timescale 1ns/1ps
`default_nettype none
module dmc_isa_slave (
	input  wire logic [7:0] want,
	input  wire logic [1:0] sense_low,
	output logic [7:0]      channel_request_line
);
	// one sense level per group, never per pin
	always_comb begin
		channel_request_line = want ^ {{4{sense_low[1]}}, {4{sense_low[0]}}};
	end
endmodule
`default_nettype wire

//--- tb/dmc_mode_ctrl_asserts.sv
// Purpose: port checks for dmc_mode_ctrl
// Assumes: command writes are mirrored here for polarity and enable
// Notes:   bound into every dmc_mode_ctrl
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_mode_ctrl_asserts #(
	parameter int NCH = `DMC_NUM_CHAN
) (
	input wire logic                         clk_sys,
	input wire logic                         rst_b,
	input wire dmc_pkg::dmc_io_wr_t          io_wr,
	input wire logic                         master_clear,
	input wire logic [7:0]                   terminal_count,
	input wire logic [7:0]                   isa_mem_target,
	input wire logic [7:0]                   channel_acknowledge_line,
	input wire dmc_pkg::dmc_chan_cfg_t [7:0] chan_cfg,
	input wire logic [7:0]                   reload_base,
	input wire logic [1:0]                   group_enabled
);
	import dmc_pkg::*;
	// ----
	// mirror of the command bits
	// ----
	logic [1:0] ah_q, ah_d, dis_q, dis_d;
	logic [7:0] ai, bad, fb;
	always_comb begin
		ah_d = ah_q;
		dis_d = dis_q;
		for (int g = 0; g < 2; g++) begin
			if (io_wr.wr && io_wr.addr == (g ? `DMC_OFS_CMD_HI : `DMC_OFS_CMD_LO)) begin
				ah_d[g] = io_wr.data[`DMC_CMD_ACK_POL];
				dis_d[g] = io_wr.data[`DMC_CMD_DISABLE];
			end
		end
		if (!rst_b || master_clear) begin
			ah_d = 2'h0;
			dis_d = 2'h0;
		end
		for (int k = 0; k < 8; k++) begin
			ai[k] = chan_cfg[k].autoinit & terminal_count[k];
			bad[k] = chan_cfg[k].strobe_en != (chan_cfg[k].xfer_type inside {2'h1, 2'h2})
				|| (chan_cfg[k].xfer_mode == 2'h3 && chan_cfg[k].xfer_type != 2'h0);
			fb[k] = isa_mem_target[k] && chan_cfg[k].timing != 2'h0;
		end
	end
	always_ff @(posedge clk_sys) begin
		ah_q <= ah_d;
		dis_q <= dis_d;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_cas4;
		$past(rst_b, 2) |-> chan_cfg[4].xfer_mode == 2'h3;
	endproperty
	a_cas4: assert property (p_cas4) else $error("channel 4 not cascade");
	property p_ack4;
		channel_acknowledge_line[4] == !ah_q[1];
	endproperty
	a_ack4: assert property (p_ack4) else $error("channel 4 acked");
	property p_one_lo;
		$onehot0(channel_acknowledge_line[3:0] ^ {4{!ah_q[0]}});
	endproperty
	a_one_lo: assert property (p_one_lo) else $error("lower acks bad");
	property p_one_hi;
		$onehot0(channel_acknowledge_line[7:4] ^ {4{!ah_q[1]}});
	endproperty
	a_one_hi: assert property (p_one_hi) else $error("upper acks bad");
	property p_grp;
		$past(dis_q, 2) == dis_q && $past(dis_q) == dis_q
			|-> group_enabled == {!dis_q[1], !dis_q[1] && !dis_q[0]};
	endproperty
	a_grp: assert property (p_grp) else $error("group enable wrong");
	property p_rld;
		$past(rst_b) |-> reload_base == $past(ai);
	endproperty
	a_rld: assert property (p_rld) else $error("reload pulse wrong");
	property p_cfg;
		$past(rst_b, 2) |-> bad == 8'h00;
	endproperty
	a_cfg: assert property (p_cfg) else $error("strobe or type wrong");
	property p_fb;
		$past(rst_b, 2) && $stable(isa_mem_target) && $past(isa_mem_target, 2) == isa_mem_target
			|-> fb == 8'h00;
	endproperty
	a_fb: assert property (p_fb) else $error("timing kept on bus memory");
endmodule
bind dmc_mode_ctrl dmc_mode_ctrl_asserts #(.NCH(NCH)) u_chk (
	.clk_sys(clk_sys),
	.rst_b(rst_b),
	.io_wr(io_wr),
	.master_clear(master_clear),
	.terminal_count(terminal_count),
	.isa_mem_target(isa_mem_target),
	.channel_acknowledge_line(channel_acknowledge_line),
	.chan_cfg(chan_cfg),
	.reload_base(reload_base),
	.group_enabled(group_enabled)
);
`default_nettype wire

//--- tb/test_dmc_mode_ctrl.sv
// Purpose: bench for dmc_mode_ctrl
// Assumes: clk_sys at 40 MHz
// Notes:   mirrors stored fields to predict chan_cfg
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_dmc_mode_ctrl;
	import dmc_pkg::*;
	logic                clk_sys = 1'b0, rst_b = 1'b0, master_clear = 1'b0;
	dmc_io_wr_t          io_wr = '0;
	logic [7:0]          tc = 8'h00, isa = 8'h00, want = 8'h00, req, ack, rld, aiv;
	logic [1:0]          ge, ah = 2'h0, sl = 2'h0;
	dmc_chan_cfg_t [7:0] cfg;
	logic [5:0]          m [8], e [8];
	int                  error_cnt = 0, check_count = 0;
	always #12.5 clk_sys = ~clk_sys;
	dmc_isa_slave sl_m (.want(want), .sense_low(sl), .channel_request_line(req));
	dmc_mode_ctrl uut (.clk_sys(clk_sys), .rst_b(rst_b), .io_wr(io_wr),
		.master_clear(master_clear), .channel_request_line(req), .terminal_count(tc),
		.isa_mem_target(isa), .channel_acknowledge_line(ack), .chan_cfg(cfg),
		.reload_base(rld), .group_enabled(ge));
	// ----
	// access tasks and prediction
	// ----
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys) io_wr <= '{a, d, 1'b1};
		@(posedge clk_sys) io_wr.wr <= 1'b0;
	endtask
	task automatic cmd(input int g, input logic [7:0] d);
		wr(g ? `DMC_OFS_CMD_HI : `DMC_OFS_CMD_LO, d);
		ah[g] <= d[7];
		sl[g] <= d[6];
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	function automatic dmc_chan_cfg_t ex(input int k);
		dmc_chan_cfg_t c;
		c.xfer_mode = (k == 4) ? 2'h3 : m[k][5:4];
		c.addr_decr = m[k][3];
		c.autoinit = m[k][2];
		c.xfer_type = (c.xfer_mode == 2'h3) ? 2'h0 : m[k][1:0];
		c.strobe_en = c.xfer_type inside {2'h1, 2'h2};
		c.timing = isa[k] ? 2'h0 : e[k][3:2];
		c.data_size = e[k][1:0];
		c.eop_in = e[k][4];
		return c;
	endfunction
	task automatic chk_all();
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		for (int k = 0; k < 8; k++) `CHK(cfg[k], ex(k))
	endtask
	// request k should be acked, 8 for none
	task automatic go(input logic [7:0] w, input int k);
		logic [7:0] idle;
		idle = {{4{!ah[1]}}, {4{!ah[0]}}};
		@(posedge clk_sys) want <= w;
		repeat (6) @(negedge clk_sys);
		`CHK(ack, idle ^ (8'h01 << k))
		@(posedge clk_sys) want <= 8'h00;
		repeat (6) @(negedge clk_sys);
		`CHK(ack, idle)
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#100us;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			m[k] = 6'h00;
			e[k] = (k < 4) ? 6'h00 : 6'h01;
		end
		chk_all();
		`CHK(ge, 2'h3)
		@(posedge clk_sys) isa <= 8'h40;
		for (int k = 0; k < 8; k++) begin
			m[k] = {2'(k), k[0], !k[0], 2'(k + 1)};
			e[k] = {1'b0, k[0], 2'(k), k[1] ? 2'h3 : 2'h1};
			wr(k < 4 ? `DMC_OFS_MODE_LO : `DMC_OFS_MODE_HI, {m[k], 2'(k)});
			wr(k < 4 ? `DMC_OFS_EXT_LO : `DMC_OFS_EXT_HI, {e[k], 2'(k)});
			aiv[k] = m[k][2];
		end
		chk_all();
		@(posedge clk_sys) tc <= 8'hEF;
		@(posedge clk_sys) tc <= 8'h00;
		@(negedge clk_sys);
		`CHK(rld, aiv & 8'hEF)
		cmd(1, 8'hC0);
		go(8'h60, 5);
		go(8'h02, 1);
		cmd(1, 8'hD4);
		`CHK(ge, 2'h0)
		go(8'h22, 8);
		cmd(1, 8'hD0);
		cmd(0, 8'h04);
		`CHK(ge, 2'h2)
		go(8'h22, 5);
		@(posedge clk_sys) master_clear <= 1'b1;
		@(posedge clk_sys) master_clear <= 1'b0;
		ah <= 2'h0;
		sl <= 2'h0;
		for (int k = 0; k < 8; k++) m[k] = 6'h00;
		chk_all();
		`CHK(ge, 2'h3)
		go(8'h22, 1);
		wrap_up();
	end
endmodule
`default_nettype wire
